// ==== pkg/acs_defs.svh ====
// Offsets, field positions, reset values and widths of the converter control registers.
// Assumes inclusion by bare name from files that need the register map.
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

// Register byte offsets on the peripheral bus
`define ACS_OFF_CONTROL 12'h000
`define ACS_OFF_CONFIG 12'h004
`define ACS_OFF_RESULT 12'h014
`define ACS_OFF_OFFSET 12'h018
`define ACS_OFF_STATUS 12'h020
`define ACS_OFF_UPPER 12'h024
`define ACS_OFF_LOWER 12'h028

// Control register bit positions
`define ACS_BIT_POWER 0
`define ACS_BIT_CAL_ENABLE 1
`define ACS_BIT_TRIGGER 2
`define ACS_BIT_SOFT_RESET 3
`define ACS_BIT_AUTO_OFFSET 4
`define ACS_BIT_STOP 5
`define ACS_BIT_CMP_ENABLE 6
`define ACS_BIT_CAL_DISARM 7
`define ACS_BIT_DMA_ENABLE 8
`define ACS_BIT_MIC_ENABLE 9

// Configuration register: filter bypass position
`define ACS_BIT_SKIP 0

// Status register: window match flag position
`define ACS_BIT_MATCH 0

// Reset values
`define ACS_RST_CONTROL 32'h00000000
`define ACS_RST_CONFIG 32'h0000000C
`define ACS_RST_RESULT 32'h00000000
`define ACS_RST_OFFSET 32'h00000000
`define ACS_RST_UPPER 32'h0FFFFFFF
`define ACS_RST_LOWER 32'h00000000

// Bus widths
`define ACS_ADDR_W 12
`define ACS_DATA_W 32

`endif

// ==== pkg/acs_pkg.sv ====
// Types shared by the converter control block.
// Assumes the register map header supplies the widths.
`include "acs_defs.svh"

package acs_pkg;

  // Control register bits kept in flops
  typedef struct packed {
    logic mic_enable;  // Microphone path on
    logic dma_enable;  // Direct memory access on
    logic cmp_enable;  // Window comparator armed
    logic auto_offset; // Automatic offset mode
    logic trigger;     // Conversion phase started
    logic cal_enable;  // Calibration armed
    logic power;       // Analog subsystem powered
  } acs_ctrl_type;

  // One peripheral bus request, as seen at the slave
  typedef struct packed {
    logic sel;                          // Slave selected
    logic enable;                       // Access phase
    logic write;                        // Write when high
    logic [`ACS_ADDR_W-1:0] addr;       // Byte address
    logic [`ACS_DATA_W-1:0] wdata;      // Write data
  } acs_bus_req_type;

  // Self-clearing command pulses
  typedef struct packed {
    logic soft_reset; // Return registers to reset
    logic stop;       // End continuous conversion
    logic disarm;     // Clear calibration enable
  } acs_cmd_type;

endpackage

// ==== hw/acs_window_cmp.sv ====
// Window comparator: flags a converted value lying between two limits.
// Assumes limits and data are in the peripheral clock domain and held stable.
`timescale 1ns/1ns

module acs_window_cmp #(
  parameter int WIDTH = 32 // Result width
) (
  input wire logic sys_clk_i,               // Peripheral clock
  input wire logic rst_n_i,                 // Synchronised reset, active low
  input wire logic arm_i,                   // Comparator enabled
  input wire logic valid_i,                 // New conversion result
  input wire logic [WIDTH-1:0] data_i,      // Converted value
  input wire logic [WIDTH-1:0] upper_i,     // Upper window limit
  input wire logic [WIDTH-1:0] lower_i,     // Lower window limit
  output logic hit_o                        // One-cycle pulse on a match
);

  logic hit_d; // Next match pulse
  logic hit_q; // Registered match pulse

  // Inclusive unsigned window test, only on a fresh armed result
  always_comb begin
    hit_d = arm_i && valid_i && (data_i >= lower_i) && (data_i <= upper_i);
  end

  // Registering keeps the long compare chain off the flag's set path
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= hit_d;
    end
  end

  assign hit_o = hit_q;

endmodule

// ==== hw/acs_top.sv ====
// Control-register logic of the on-chip converter, reached over its peripheral bus.
// Assumes the analog datapath delivers results and calibration values synchronously.
// Behaviour
// - Power bit switches analog subsystem, not microphone
// - Trigger write starts conversion, ignored microphone mode
// - Calibration runs when enable and auto-offset set
// - Writing zero never clears calibration enable
// - Soft reset restores registers except offset and match flag, reads zero
// - Stop ends conversion, clears four control bits
// - Armed comparator sets match flag inside window
// - Disarm clears calibration enable, reads zero
// - Upper limit resets high, lower to zero
`timescale 1ns/1ns
`include "acs_defs.svh"

module acs_top #(
  parameter int DATA_W = `ACS_DATA_W // Register and result width
) (
  input wire logic sys_clk_i,                  // Peripheral clock, 20 MHz
  input wire logic nrst_i,                     // Asynchronous reset, active low
  input wire logic psel_i,                     // Bus slave select
  input wire logic penable_i,                  // Bus access phase
  input wire logic pwrite_i,                   // Bus write
  input wire logic [`ACS_ADDR_W-1:0] paddr_i,  // Bus byte address
  input wire logic [DATA_W-1:0] pwdata_i,      // Bus write data
  output logic [DATA_W-1:0] prdata_o,          // Bus read data
  output logic pready_o,                       // Bus ready, high except during reset
  output logic pslverr_o,                      // Bus error on unmapped address
  input wire logic conv_valid_i,               // Conversion result strobe
  input wire logic [DATA_W-1:0] conv_data_i,   // Conversion result
  input wire logic cal_done_i,                 // Calibration value strobe
  input wire logic [DATA_W-1:0] cal_value_i,   // Calibration value, both formats
  output logic analog_power_o,                 // Analog subsystem powered
  output logic conv_start_o,                   // One-cycle start pulse
  output logic conv_stop_o,                    // One-cycle stop pulse
  output logic cal_run_o,                      // Calibration routine enabled
  output logic dma_enable_o,                   // Direct memory access enable
  output logic mic_enable_o,                   // Microphone path enable
  output logic match_flag_o                    // Window match flag
);

  // Reset release synchroniser
  logic rst_meta_q; // First stage, read only by second
  logic rst_n_q;    // Released reset used by the design

  // Register state
  acs_pkg::acs_ctrl_type ctrl_q, ctrl_d;     // Control bits
  acs_pkg::acs_cmd_type cmd_q, cmd_d;        // Command pulses
  acs_pkg::acs_bus_req_type req;             // Bundled bus request
  logic [DATA_W-1:0] config_q, config_d;     // Configuration register
  logic [DATA_W-1:0] result_q, result_d;     // Latest conversion result
  logic [DATA_W-1:0] offset_q, offset_d;     // Calibration offset
  logic [DATA_W-1:0] upper_q, upper_d;       // Upper window limit
  logic [DATA_W-1:0] lower_q, lower_d;       // Lower window limit
  logic match_q, match_d;                    // Sticky window match flag
  logic power_q, power_d;                    // Registered analog power
  logic start_q, start_d;                    // Registered start pulse
  logic calrun_q, calrun_d;                  // Registered calibration run
  logic [DATA_W-1:0] rdata_q, rdata_d;       // Registered read data
  logic slverr_q, slverr_d;                  // Registered error
  logic ready_q;                             // Registered ready
  logic hit;                                 // Comparator match pulse
  logic wr_acc;                              // Write in access phase
  logic rd_setup;                            // Read in setup phase

  // Decode an address to mapped or not; used for reads and writes
  function automatic logic acs_mapped(input logic [`ACS_ADDR_W-1:0] a);
    acs_mapped = (a == `ACS_OFF_CONTROL) || (a == `ACS_OFF_CONFIG) ||
                 (a == `ACS_OFF_RESULT) || (a == `ACS_OFF_OFFSET) ||
                 (a == `ACS_OFF_STATUS) || (a == `ACS_OFF_UPPER) ||
                 (a == `ACS_OFF_LOWER);
  endfunction

  // Pack control bits into the register image; commands read zero
  function automatic logic [DATA_W-1:0] acs_ctrl_word(input acs_pkg::acs_ctrl_type c);
    logic [DATA_W-1:0] w;
    w = '0;
    w[`ACS_BIT_POWER] = c.power;
    w[`ACS_BIT_CAL_ENABLE] = c.cal_enable;
    w[`ACS_BIT_TRIGGER] = c.trigger;
    w[`ACS_BIT_AUTO_OFFSET] = c.auto_offset;
    w[`ACS_BIT_CMP_ENABLE] = c.cmp_enable;
    w[`ACS_BIT_DMA_ENABLE] = c.dma_enable;
    w[`ACS_BIT_MIC_ENABLE] = c.mic_enable;
    acs_ctrl_word = w;
  endfunction

  // Reset is asserted at once and released after two clean edges
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // Bundle the bus request and decode its phase
  always_comb begin
    req = '{sel: psel_i, enable: penable_i, write: pwrite_i, addr: paddr_i, wdata: pwdata_i};
    wr_acc = req.sel && req.enable && req.write && acs_mapped(req.addr);
    rd_setup = req.sel && !req.enable && !req.write;
  end

  // Command pulses: one cycle after the accepted write
  always_comb begin
    cmd_d = '0;
    if (wr_acc && (req.addr == `ACS_OFF_CONTROL)) begin
      cmd_d.soft_reset = req.wdata[`ACS_BIT_SOFT_RESET];
      cmd_d.stop = req.wdata[`ACS_BIT_STOP];
      cmd_d.disarm = req.wdata[`ACS_BIT_CAL_DISARM];
    end
  end

  // Register file next state; pending commands take priority over writes
  always_comb begin
    ctrl_d = ctrl_q;
    config_d = config_q;
    result_d = result_q;
    offset_d = offset_q;
    upper_d = upper_q;
    lower_d = lower_q;
    start_d = 1'b0;
    // Result capture from the datapath
    if (conv_valid_i) begin
      result_d = conv_data_i;
    end
    // Calibration lands in the offset register in the bypass-chosen format
    if (cal_done_i && calrun_q) begin
      if (config_q[`ACS_BIT_SKIP]) begin
        offset_d = {{(DATA_W-16){1'b0}}, cal_value_i[15:0]};
      end else begin
        offset_d = {{(DATA_W-16){1'b0}}, cal_value_i[DATA_W-1:DATA_W-16]};
      end
    end
    // Software writes
    if (wr_acc) begin
      case (req.addr)
        `ACS_OFF_CONTROL: begin
          ctrl_d.power = req.wdata[`ACS_BIT_POWER];
          // Only a one arms calibration; zero leaves it alone
          if (req.wdata[`ACS_BIT_CAL_ENABLE]) begin
            ctrl_d.cal_enable = 1'b1;
          end
          ctrl_d.auto_offset = req.wdata[`ACS_BIT_AUTO_OFFSET];
          ctrl_d.cmp_enable = req.wdata[`ACS_BIT_CMP_ENABLE];
          ctrl_d.dma_enable = req.wdata[`ACS_BIT_DMA_ENABLE];
          ctrl_d.mic_enable = req.wdata[`ACS_BIT_MIC_ENABLE];
          // Start is dropped in microphone mode
          if (req.wdata[`ACS_BIT_TRIGGER] && !req.wdata[`ACS_BIT_MIC_ENABLE]) begin
            ctrl_d.trigger = 1'b1;
            start_d = 1'b1;
          end else begin
            ctrl_d.trigger = 1'b0;
          end
        end
        `ACS_OFF_CONFIG: config_d = req.wdata;
        `ACS_OFF_OFFSET: offset_d = req.wdata;
        `ACS_OFF_UPPER: upper_d = req.wdata;
        `ACS_OFF_LOWER: lower_d = req.wdata;
        default: begin
          // Result and status are not plain stores
        end
      endcase
    end
    // Disarm clears calibration enable
    if (cmd_q.disarm) begin
      ctrl_d.cal_enable = 1'b0;
    end
    // Stop clears trigger, power, dma and microphone
    if (cmd_q.stop) begin
      ctrl_d.trigger = 1'b0;
      ctrl_d.power = 1'b0;
      ctrl_d.dma_enable = 1'b0;
      ctrl_d.mic_enable = 1'b0;
      start_d = 1'b0;
    end
    // Soft reset wins over everything; offset is not in its list
    if (cmd_q.soft_reset) begin
      ctrl_d = '0;
      config_d = `ACS_RST_CONFIG;
      result_d = `ACS_RST_RESULT;
      upper_d = `ACS_RST_UPPER;
      lower_d = `ACS_RST_LOWER;
      start_d = 1'b0;
    end
    // Power has no effect in microphone mode
    power_d = ctrl_d.power && !ctrl_d.mic_enable;
    // Calibration enabled only when both bits are set
    calrun_d = ctrl_d.cal_enable && ctrl_d.auto_offset;
  end

  // Match flag: set wins over a same-cycle write-one clear
  always_comb begin
    match_d = match_q;
    if (wr_acc && (req.addr == `ACS_OFF_STATUS) && req.wdata[`ACS_BIT_MATCH]) begin
      match_d = 1'b0;
    end
    if (hit) begin
      match_d = 1'b1;
    end
  end

  // Read data is fetched in the setup phase so it stands in the access phase
  always_comb begin
    rdata_d = rdata_q;
    slverr_d = 1'b0;
    if (rd_setup) begin
      case (req.addr)
        `ACS_OFF_CONTROL: rdata_d = acs_ctrl_word(ctrl_q);
        `ACS_OFF_CONFIG: rdata_d = config_q;
        `ACS_OFF_RESULT: rdata_d = result_q;
        `ACS_OFF_OFFSET: rdata_d = offset_q;
        `ACS_OFF_STATUS: rdata_d = {{(DATA_W-1){1'b0}}, match_q};
        `ACS_OFF_UPPER: rdata_d = upper_q;
        `ACS_OFF_LOWER: rdata_d = lower_q;
        default: rdata_d = '0;
      endcase
    end
    if (req.sel && !req.enable) begin
      slverr_d = !acs_mapped(req.addr);
    end else if (req.sel) begin
      slverr_d = slverr_q;
    end
  end

  // All register state; limits reset to the window 0 to 0FFFFFFF
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= '0;
      cmd_q <= '0;
      config_q <= `ACS_RST_CONFIG;
      result_q <= `ACS_RST_RESULT;
      offset_q <= `ACS_RST_OFFSET;
      upper_q <= `ACS_RST_UPPER;
      lower_q <= `ACS_RST_LOWER;
      match_q <= 1'b0;
      power_q <= 1'b0;
      start_q <= 1'b0;
      calrun_q <= 1'b0;
      rdata_q <= '0;
      slverr_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      cmd_q <= cmd_d;
      config_q <= config_d;
      result_q <= result_d;
      offset_q <= offset_d;
      upper_q <= upper_d;
      lower_q <= lower_d;
      match_q <= match_d;
      power_q <= power_d;
      start_q <= start_d;
      calrun_q <= calrun_d;
      rdata_q <= rdata_d;
      slverr_q <= slverr_d;
      ready_q <= 1'b1;
    end
  end

  // Comparator sees only results arriving while armed
  acs_window_cmp #(
    .WIDTH(DATA_W)
  ) u_window (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_q),
    .arm_i(ctrl_q.cmp_enable),
    .valid_i(conv_valid_i),
    .data_i(conv_data_i),
    .upper_i(upper_q),
    .lower_i(lower_q),
    .hit_o(hit)
  );

  // Outputs straight from flops
  assign prdata_o = rdata_q;
  assign pready_o = ready_q;
  assign pslverr_o = slverr_q;
  assign analog_power_o = power_q;
  assign conv_start_o = start_q;
  assign conv_stop_o = cmd_q.stop;
  assign cal_run_o = calrun_q;
  assign dma_enable_o = ctrl_q.dma_enable;
  assign mic_enable_o = ctrl_q.mic_enable;
  assign match_flag_o = match_q;

endmodule

// ==== dv/acs_top_asserts.sv ====
// Port-level checker for the converter control block.
// Assumes a bind onto acs_top; one clock domain, reset active low.
`timescale 1ns/1ns
module acs_top_asserts #(
  parameter int DATA_W = 32 // Register width
) (
  input wire logic sys_clk_i, // Peripheral clock
  input wire logic nrst_i, // Reset, active low
  input wire logic psel_i, // Bus select
  input wire logic penable_i, // Bus access phase
  input wire logic pwrite_i, // Bus write
  input wire logic [11:0] paddr_i, // Bus address
  input wire logic [DATA_W-1:0] pwdata_i, // Bus write data
  input wire logic conv_valid_i, // Result strobe
  input wire logic analog_power_o, // Analog power
  input wire logic conv_start_o, // Start pulse
  input wire logic conv_stop_o, // Stop pulse
  input wire logic cal_run_o, // Calibration running
  input wire logic dma_enable_o, // DMA enable
  input wire logic mic_enable_o, // Microphone enable
  input wire logic match_flag_o // Window match flag
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // Accepted control write; commands excluded where they would override the data
  wire wr_c = psel_i && penable_i && pwrite_i && paddr_i == 12'h000;
  wire wr_plain = wr_c && !pwdata_i[3] && !pwdata_i[5];
  // Stop pulse, then power, dma and microphone outputs gone
  sequence s_stop_done;
    conv_stop_o ##[1:2] (!analog_power_o && !dma_enable_o && !mic_enable_o);
  endsequence
  // Power, calibration, dma and microphone outputs of a reset register state
  sequence s_reset_done;
    ##[1:2] (!analog_power_o && !cal_run_o && !dma_enable_o && !mic_enable_o);
  endsequence
  a_power_follows_write: assert property (wr_plain |=>
    analog_power_o == ($past(pwdata_i[0]) && !$past(pwdata_i[9])))
    else $error("power level wrong");
  a_start_pulse_given: assert property (wr_plain && pwdata_i[2] && !pwdata_i[9]
    |=> conv_start_o) else $error("start pulse missing");
  a_start_mic_blocked: assert property (wr_c && pwdata_i[9] |=> !conv_start_o [*2])
    else $error("start in microphone mode");
  a_stop_clears_bits: assert property (wr_c && pwdata_i[5] && !pwdata_i[3]
    |=> s_stop_done) else $error("stop did not clear");
  a_stop_single_pulse: assert property ($rose(conv_stop_o) |=> !conv_stop_o)
    else $error("stop pulse too long");
  a_cal_zero_kept: assert property (cal_run_o && wr_plain && pwdata_i[4]
    && !pwdata_i[7] |=> cal_run_o [*2]) else $error("calibration dropped");
  a_disarm_stops_cal: assert property (wr_c && pwdata_i[7] |=> ##[1:2] !cal_run_o)
    else $error("disarm ignored");
  a_match_after_valid: assert property ($rose(match_flag_o) |-> $past(conv_valid_i, 2))
    else $error("match without result");
  a_soft_reset_clears: assert property (wr_c && pwdata_i[3] |=> s_reset_done)
    else $error("soft reset incomplete");
endmodule

// ==== dv/testbench.sv ====
// Self-checking bench for the converter control block over its register bus.
// Assumes acs_top with 32-bit registers and zero-wait bus answers.
`timescale 1ns/1ns
module testbench;
  logic sys_clk_i, nrst_i, psel_i, penable_i, pwrite_i; // Clock, reset, bus controls
  logic [11:0] paddr_i; // Bus address
  logic [31:0] pwdata_i, prdata_o, conv_data_i, cal_value_i; // Data buses
  logic pready_o, pslverr_o, conv_valid_i, cal_done_i; // Handshakes
  logic analog_power_o, conv_start_o, conv_stop_o, cal_run_o; // Control outputs
  logic dma_enable_o, mic_enable_o, match_flag_o; // Control outputs
  logic [31:0] rd_v; // Last read data
  logic err_v, rdy_v; // Last error and ready
  int error_cnt = 0, checks_done = 0, cyc = 0, starts = 0, stops = 0; // Counters
  logic [11:0] ra[7] = '{12'h000, 12'h004, 12'h014, 12'h018, 12'h020, 12'h024, 12'h028};
  logic [31:0] rv[7] = '{32'h0, 32'h0000000C, 32'h0, 32'h0, 32'h0, 32'h0FFFFFFF, 32'h0};
  acs_top acs_top_i (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .conv_valid_i(conv_valid_i),
    .conv_data_i(conv_data_i),
    .cal_done_i(cal_done_i),
    .cal_value_i(cal_value_i),
    .analog_power_o(analog_power_o),
    .conv_start_o(conv_start_o),
    .conv_stop_o(conv_stop_o),
    .cal_run_o(cal_run_o),
    .dma_enable_o(dma_enable_o),
    .mic_enable_o(mic_enable_o),
    .match_flag_o(match_flag_o)
  );
  // Free-running 20 MHz clock
  initial begin
    sys_clk_i = 0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  // Pulse counters and hang guard; a pulse is one cycle, so count per edge
  always @(posedge sys_clk_i) begin
    cyc++;
    if (conv_start_o === 1'b1) starts++;
    if (conv_stop_o === 1'b1) stops++;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Setup then access; answer taken at the edge that ends the access phase
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    #1 psel_i = 1;
    pwrite_i = wr;
    paddr_i = a;
    pwdata_i = d;
    @(posedge sys_clk_i);
    #1 penable_i = 1;
    @(posedge sys_clk_i);
    rd_v = prdata_o;
    err_v = pslverr_o;
    rdy_v = pready_o;
    #1 psel_i = 0;
    penable_i = 0;
  endtask
  // Write, then let command effects reach the outputs
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(32'(rdy_v), 32'h1);
    chk(32'(err_v), 32'h0);
    chk(rd_v, exp);
  endtask
  // One-cycle strobe of a result or a calibration value
  task automatic strobe(input logic cal, input logic [31:0] d);
    @(posedge sys_clk_i);
    #1 conv_valid_i = !cal;
    cal_done_i = cal;
    conv_data_i = d;
    cal_value_i = d;
    @(posedge sys_clk_i);
    #1 conv_valid_i = 0;
    cal_done_i = 0;
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    nrst_i = 0;
    psel_i = 0;
    penable_i = 0;
    pwrite_i = 0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    conv_valid_i = 0;
    conv_data_i = 32'h0;
    cal_done_i = 0;
    cal_value_i = 32'h0;
    repeat (8) @(posedge sys_clk_i);
    #1 nrst_i = 1;
    repeat (4) @(posedge sys_clk_i);
    #1;
    for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
    bus(1'b0, 12'h030, 32'h0);
    chk(32'(err_v), 32'h1); // Unmapped place answers with an error
    wr(12'h000, 32'h001);
    chk(32'(analog_power_o), 32'h1);
    wr(12'h000, 32'h005);
    chk(starts, 1);
    rd(12'h000, 32'h005);
    wr(12'h000, 32'h205);
    chk(starts, 1);
    rd(12'h000, 32'h201);
    chk(32'({analog_power_o, mic_enable_o}), 32'h1);
    wr(12'h000, 32'h355);
    chk(32'({dma_enable_o, mic_enable_o}), 32'h3);
    // Stop in the same write that sets power, dma and microphone must still clear them
    wr(12'h000, 32'h371);
    chk(stops, 1);
    rd(12'h000, 32'h050);
    chk(32'({analog_power_o, dma_enable_o, mic_enable_o}), 32'h0);
    // Calibration: both formats of the offset, then disarm
    wr(12'h000, 32'h012);
    chk(32'(cal_run_o), 32'h1);
    strobe(1'b1, 32'hABCD1234);
    rd(12'h018, 32'h0000ABCD);
    wr(12'h004, 32'h0000000D);
    strobe(1'b1, 32'h55551234);
    rd(12'h018, 32'h00001234);
    wr(12'h000, 32'h010);
    rd(12'h000, 32'h012);
    wr(12'h000, 32'h090);
    rd(12'h000, 32'h010);
    strobe(1'b1, 32'hFFFF9999);
    rd(12'h018, 32'h00001234);
    // Window comparator, upper edge inclusive
    wr(12'h024, 32'h100);
    wr(12'h028, 32'h010);
    wr(12'h000, 32'h040);
    strobe(1'b0, 32'h200);
    chk(32'(match_flag_o), 32'h0);
    strobe(1'b0, 32'h100);
    chk(32'(match_flag_o), 32'h1);
    rd(12'h020, 32'h1);
    wr(12'h020, 32'h1);
    rd(12'h020, 32'h0);
    wr(12'h014, 32'h5);
    rd(12'h014, 32'h100); // Result place is read-only
    wr(12'h000, 32'h000);
    strobe(1'b0, 32'h050);
    chk(32'(match_flag_o), 32'h0);
    // Soft reset; the offset is kept, so skip it
    wr(12'h004, 32'h1);
    wr(12'h000, 32'h041);
    wr(12'h000, 32'h04B);
    for (int i = 0; i < 7; i++) if (i != 3) rd(ra[i], rv[i]);
    tally_and_finish();
  end
endmodule
bind acs_top acs_top_asserts #(.DATA_W(DATA_W)) acs_top_asserts_i (
  .sys_clk_i(sys_clk_i),
  .nrst_i(nrst_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .pwdata_i(pwdata_i),
  .conv_valid_i(conv_valid_i),
  .analog_power_o(analog_power_o),
  .conv_start_o(conv_start_o),
  .conv_stop_o(conv_stop_o),
  .cal_run_o(cal_run_o),
  .dma_enable_o(dma_enable_o),
  .mic_enable_o(mic_enable_o),
  .match_flag_o(match_flag_o)
);
